/* File: nvhc_host.sv */
`timescale 1ns/1ps
`include "nvhc_params.svh"

// Operation
// - Address stays fixed whole time chip select is low during protect sequences.
// - Page accesses change only column bits, bus rate at most 33 MHz.
// - Write strobe stays high through power transitions and reset.
// - Byte-wide mode joins lanes, extra address bit picks the lane.
// - Four-word page transaction needs extra clocks for latency and precharge.
// - Chip select low only during actual accesses to save power; code keeps it low one more cycle in NVHC_HOLD after each non-protect access.
// - Precharge by chip select high for minimum time, or by row change.
// - Six reads, protect byte, complement, one write, one read set protection.
module nvhc_host
  import nvhc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [17:0] req_addr_in,
  input  wire logic [1:0]  req_be_in,
  input  wire logic [15:0] req_wdata_in,
  input  wire logic        byte_mode_in,
  input  wire logic        prot_start_in,
  input  wire logic [7:0]  prot_byte_in,
  output logic             ready_out,
  output logic             done_out,
  output logic [15:0]      rdata_out,
  output logic             prot_done_out,
  output logic             chip_select_low_out,
  output logic             write_strobe_low_out,
  output logic             output_enable_low_out,
  output logic             upper_byte_select_low_out,
  output logic             lower_byte_select_low_out,
  output logic [16:0]      mem_addr_out,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe_out
);
  nvhc_main_t  q;
  nvhc_main_t  d;
  nvhc_tmr_if  tmr ();
  logic        ptake;
  logic        utake;
  logic [16:0] na;
  logic [3:0]  ps;
  logic [16:0] sa;
  logic        sw;
  logic [15:0] sd;

  nvhc_timer u_timer (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .tmr        (tmr)
  );

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.prot_done = 1'b0;
    tmr.load = 1'b0;
    tmr.val = 4'h0;
    ptake = prot_start_in & q.ready & (q.state == NVHC_IDLE);
    utake = req_valid_in & q.ready & ~ptake;
    na = byte_mode_in ? req_addr_in[17:1] : req_addr_in[16:0];
    ps = ptake ? 4'h0 : q.step + 4'h1;
    sw = 1'b0;
    sd = 16'h0000;
    // Fixed unlock order; no page mode so every step gets its own select
    case (ps)
      4'h0:    sa = `NVHC_WP_A0;
      4'h1:    sa = `NVHC_WP_A1;
      4'h2:    sa = `NVHC_WP_A2;
      4'h3:    sa = `NVHC_WP_A3;
      4'h4:    sa = `NVHC_WP_A4;
      4'h5:    sa = `NVHC_WP_A5;
      4'h6: begin
        sa = `NVHC_WP_A6;
        sw = 1'b1;
        sd = {8'h00, ptake ? prot_byte_in : q.pbyte};
      end
      4'h7: begin
        sa = `NVHC_WP_A7;
        sw = 1'b1;
        sd = {8'h00, ~q.pbyte};
      end
      4'h8: begin
        sa = `NVHC_WP_A8;
        sw = 1'b1;
      end
      default: sa = `NVHC_WP_A9;
    endcase

    case (q.state)
      NVHC_IDLE: begin
        d.ce_n = 1'b1;
        if (ptake) begin
          d.prot = 1'b1;
          d.step = 4'h0;
          d.pbyte = prot_byte_in;
          d.addr = sa;
          d.wr = sw;
          d.wdata = sd;
          d.be = 2'b11;
          d.bmode = 1'b0;
          d.hisel = 1'b0;
        end else if (utake) begin
          d.addr = na;
          d.wr = req_write_in;
          d.wdata = byte_mode_in ? {2{req_wdata_in[7:0]}} : req_wdata_in;
          d.be = byte_mode_in ? (req_addr_in[0] ? 2'b10 : 2'b01) : req_be_in;
          d.bmode = byte_mode_in;
          d.hisel = byte_mode_in & req_addr_in[0];
        end
        if (ptake | utake) begin
          d.ready = 1'b0;
          d.state = NVHC_SETUP;
          tmr.load = 1'b1;
          tmr.val = `NVHC_TAS_CYC - 4'h1;
        end
      end
      NVHC_SETUP, NVHC_COLCHG: begin
        // Address settles before select or strobe moves
        if (tmr.done) begin
          d.state = NVHC_ACCESS;
          d.ce_n = 1'b0;
          d.oe_n = q.wr;
          d.we_n = ~q.wr;
          d.ub_n = ~q.be[1];
          d.lb_n = ~q.be[0];
          d.dq_oe = q.wr;
          tmr.load = 1'b1;
          tmr.val = `NVHC_TACC_CYC - 4'h1;
        end
      end
      NVHC_ACCESS: begin
        if (tmr.done) begin
          d.we_n = 1'b1;
          d.oe_n = 1'b1;
          if (!q.wr) begin
            d.rdata = q.hisel ? {8'h00, dq_in[15:8]} : (q.bmode ? {8'h00, dq_in[7:0]} : dq_in);
          end
          if (q.prot) begin
            // Select rises after every step so address never moves under it
            d.state = NVHC_PRECH;
            d.ce_n = 1'b1;
            d.ub_n = 1'b1;
            d.lb_n = 1'b1;
            tmr.load = 1'b1;
            tmr.val = `NVHC_TPC_CYC - 4'h1;
          end else begin
            d.done = 1'b1;
            d.ready = 1'b1;
            d.state = NVHC_HOLD;
          end
        end
      end
      NVHC_HOLD: begin
        d.ready = 1'b0;
        d.dq_oe = 1'b0;
        if (utake) begin
          d.addr = na;
          d.wr = req_write_in;
          d.wdata = byte_mode_in ? {2{req_wdata_in[7:0]}} : req_wdata_in;
          d.be = byte_mode_in ? (req_addr_in[0] ? 2'b10 : 2'b01) : req_be_in;
          d.bmode = byte_mode_in;
          d.hisel = byte_mode_in & req_addr_in[0];
        end
        // Same row keeps select low, row change or idle forces precharge
        if (utake && na[`NVHC_ROW_HI:`NVHC_ROW_LO] == q.addr[`NVHC_ROW_HI:`NVHC_ROW_LO]) begin
          d.state = NVHC_COLCHG;
          tmr.load = 1'b1;
          tmr.val = `NVHC_TAS_CYC - 4'h1;
        end else begin
          d.pend = utake;
          d.state = NVHC_PRECH;
          d.ce_n = 1'b1;
          d.ub_n = 1'b1;
          d.lb_n = 1'b1;
          tmr.load = 1'b1;
          tmr.val = `NVHC_TPC_CYC - 4'h1;
        end
      end
      NVHC_PRECH: begin
        // Data held one cycle past strobe rise, so no zero-hold write
        d.dq_oe = 1'b0;
        if (tmr.done) begin
          if (q.prot && q.step == `NVHC_WP_LAST) begin
            d.prot = 1'b0;
            d.prot_done = 1'b1;
            d.ready = 1'b1;
            d.state = NVHC_IDLE;
          end else if (q.prot) begin
            d.step = ps;
            d.addr = sa;
            d.wr = sw;
            d.wdata = sd;
            d.state = NVHC_SETUP;
            tmr.load = 1'b1;
            tmr.val = `NVHC_TAS_CYC - 4'h1;
          end else if (q.pend) begin
            d.pend = 1'b0;
            d.state = NVHC_SETUP;
            tmr.load = 1'b1;
            tmr.val = `NVHC_TAS_CYC - 4'h1;
          end else begin
            d.ready = 1'b1;
            d.state = NVHC_IDLE;
          end
        end
      end
      default: begin
        d = NVHC_MAIN_RST;
      end
    endcase
  end

  // Strobe resets high so no write can slip in around power events
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= NVHC_MAIN_RST;
    end else begin
      q <= d;
    end
  end

  assign ready_out = q.ready;
  assign done_out = q.done;
  assign rdata_out = q.rdata;
  assign prot_done_out = q.prot_done;
  assign chip_select_low_out = q.ce_n;
  assign write_strobe_low_out = q.we_n;
  assign output_enable_low_out = q.oe_n;
  assign upper_byte_select_low_out = q.ub_n;
  assign lower_byte_select_low_out = q.lb_n;
  assign mem_addr_out = q.addr;
  assign dq_out = q.wdata;
  assign dq_oe_out = q.dq_oe;
endmodule

/* File: nvhc_params.svh */
`ifndef NVHC_PARAMS_SVH
`define NVHC_PARAMS_SVH

`define NVHC_CLK_MHZ      20
`define NVHC_CLK_NS       (1000 / `NVHC_CLK_MHZ)
`define NVHC_CYC(ns)      (4'((((ns) + `NVHC_CLK_NS - 1) / `NVHC_CLK_NS)))

`define NVHC_TAS_NS       10
`define NVHC_TACC_NS      70
`define NVHC_TPC_NS       70
`define NVHC_PAGE_MAX_MHZ 33

`define NVHC_TAS_CYC      `NVHC_CYC(`NVHC_TAS_NS)
`define NVHC_TACC_CYC     `NVHC_CYC(`NVHC_TACC_NS)
`define NVHC_TPC_CYC      `NVHC_CYC(`NVHC_TPC_NS)

`define NVHC_WP_A0        17'h1_2555
`define NVHC_WP_A1        17'h1_DAAA
`define NVHC_WP_A2        17'h0_1333
`define NVHC_WP_A3        17'h0_ECCC
`define NVHC_WP_A4        17'h0_00FF
`define NVHC_WP_A5        17'h1_FF00
`define NVHC_WP_A6        17'h1_DAAA
`define NVHC_WP_A7        17'h0_ECCC
`define NVHC_WP_A8        17'h0_FF00
`define NVHC_WP_A9        17'h0_0000
`define NVHC_WP_LAST      4'h9
`define NVHC_ROW_HI       16
`define NVHC_ROW_LO       2

`endif

/* File: nvhc_pkg.sv */
package nvhc_pkg;

  typedef enum logic [2:0] {
    NVHC_IDLE,
    NVHC_SETUP,
    NVHC_ACCESS,
    NVHC_HOLD,
    NVHC_COLCHG,
    NVHC_PRECH
  } nvhc_state_t;

  typedef struct packed {
    nvhc_state_t state;
    logic [16:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        wr;
    logic        bmode;
    logic        hisel;
    logic        pend;
    logic        prot;
    logic [3:0]  step;
    logic [7:0]  pbyte;
    logic        ready;
    logic        done;
    logic        prot_done;
    logic [15:0] rdata;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        ub_n;
    logic        lb_n;
    logic        dq_oe;
  } nvhc_main_t;

  typedef struct packed {
    logic [3:0] cnt;
  } nvhc_tmr_t;

  localparam nvhc_main_t NVHC_MAIN_RST = '{
    state: NVHC_IDLE, addr: '0, wdata: '0, be: '0, wr: 1'b0, bmode: 1'b0,
    hisel: 1'b0, pend: 1'b0, prot: 1'b0, step: '0, pbyte: '0, ready: 1'b1,
    done: 1'b0, prot_done: 1'b0, rdata: '0, ce_n: 1'b1, we_n: 1'b1,
    oe_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1, dq_oe: 1'b0};

endpackage

/* File: nvhc_tmr_if.sv */
`timescale 1ns/1ps
interface nvhc_tmr_if;
  logic       load;
  logic [3:0] val;
  logic       done;
  modport ctrl (output load, output val, input done);
  modport tmr  (input load, input val, output done);
endinterface

/* File: nvhc_timer.sv */
`timescale 1ns/1ps
module nvhc_timer
  import nvhc_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  nvhc_tmr_if.tmr   tmr
);
  nvhc_tmr_t q;
  nvhc_tmr_t d;

  // Load N-1 to stay exactly N cycles in the caller's state
  always_comb begin
    d = q;
    if (tmr.load) begin
      d.cnt = tmr.val;
    end else if (q.cnt != 4'h0) begin
      d.cnt = q.cnt - 4'h1;
    end
  end

  assign tmr.done = (q.cnt == 4'h0);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '{cnt: 4'h0};
    end else begin
      q <= d;
    end
  end
endmodule

/* File: nvhc_host_monitor.sv */
`timescale 1ns/1ps
module nvhc_host_monitor (
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic        req_valid_in,
  input wire logic        prot_start_in,
  input wire logic        ready_out,
  input wire logic        done_out,
  input wire logic        prot_done_out,
  input wire logic        chip_select_low_out,
  input wire logic        write_strobe_low_out,
  input wire logic        output_enable_low_out,
  input wire logic [16:0] mem_addr_out,
  input wire logic        dq_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  row_stable_a: assert property (
    !chip_select_low_out && $past(!chip_select_low_out) |-> $stable(mem_addr_out[16:2]))
    else $error("row moved while selected");
  addr_setup_a: assert property (
    $fell(chip_select_low_out) |-> $stable(mem_addr_out)) else $error("no address setup");
  we_reset_a: assert property (disable iff (1'b0)
    !arst_n_in |-> write_strobe_low_out && chip_select_low_out) else $error("strobe low in reset");
  precharge_a: assert property (
    $rose(chip_select_low_out) |-> chip_select_low_out [*2]) else $error("precharge too short");
  first_done_a: assert property (
    ready_out && chip_select_low_out && req_valid_in && !prot_start_in |-> ##4 done_out)
    else $error("done late");
  done_hold_a: assert property (
    done_out |-> ready_out && !chip_select_low_out) else $error("done outside hold");
  prot_seq_a: assert property (
    prot_start_in && ready_out && chip_select_low_out |-> ##[40:70] prot_done_out)
    else $error("protect sequence length");
  dq_dir_a: assert property (
    dq_oe_out |-> output_enable_low_out) else $error("bus contention");
endmodule
bind nvhc_host nvhc_host_monitor i_mon (.*);

/* File: nvhc_mem_model.sv */
`timescale 1ns/1ps
module nvhc_mem_model #(
  parameter int DLY_NS = 30
) (
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        ub_n_in,
  input  wire logic        lb_n_in,
  input  wire logic [16:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out
);
  logic [15:0] mem [131072] = '{default: 16'h0000};
  logic [16:0] sq [10] = '{17'h1_2555, 17'h1_DAAA, 17'h0_1333, 17'h0_ECCC, 17'h0_00FF,
                           17'h1_FF00, 17'h1_DAAA, 17'h0_ECCC, 17'h0_FF00, 17'h0_0000};
  logic [15:0] junk = 16'h0001;
  logic [7:0]  pb;
  logic [7:0]  prot = 8'h00;
  logic [3:0]  trk = 4'h0;
  logic        wr_seen = 1'b0;
  logic        ok = 1'b0;
  logic        hit;
  logic        drv;
  logic        wcs = 1'b0;
  // No pull-ups: idle lanes keep changing so stale data never passes
  always #50 junk = {junk[14:0], ~junk[15]};
  assign drv = !cs_n_in && !oe_n_in && we_n_in;
  assign #(DLY_NS) dq_out = {(drv && !ub_n_in) ? mem[addr_in][15:8] : junk[15:8],
                             (drv && !lb_n_in) ? mem[addr_in][7:0] : junk[7:0]};
  // Select and strobe move on one edge; look at the select once both settled
  always @(negedge we_n_in) begin
    wr_seen = 1'b1;
    #1 wcs = (cs_n_in === 1'b0);
  end
  always @(posedge we_n_in) begin
    if (wcs) begin
      if (trk == 4'h6) pb = dq_in[7:0];
      else if (trk == 4'h7) ok = (dq_in[7:0] === ~pb);
      else if (trk < 4'h6 && !prot[addr_in[16:14]]) begin
        if (!ub_n_in) mem[addr_in][15:8] = dq_in[15:8];
        if (!lb_n_in) mem[addr_in][7:0] = dq_in[7:0];
      end
    end
  end
  // Steps counted at deselect, so a tied select never advances
  always @(posedge cs_n_in) begin
    // Strobe released on the same edge is handled first
    #1;
    hit = addr_in === sq[trk] && wr_seen === (trk inside {[4'h6:4'h8]}) && (trk != 4'h7 || ok);
    if (hit && trk == 4'h9) begin
      prot = pb;
      trk = 4'h0;
    end
    else if (hit) trk = trk + 4'h1;
    else trk = (addr_in === sq[0] && !wr_seen) ? 4'h1 : 4'h0;
    wr_seen = 1'b0;
  end
endmodule

/* File: nvhc_host_tb.sv */
`timescale 1ns/1ps
module nvhc_host_tb;
  typedef struct {logic [15:0] e; logic [15:0] m;} nvhc_note_t;
  logic ref_clk_in = 0, arst_n_in = 1, req_valid_in = 0, req_write_in = 0, byte_mode_in = 0;
  logic prot_start_in = 0, ready_out, done_out, prot_done_out, chip_select_low_out, dq_oe_out;
  logic write_strobe_low_out, output_enable_low_out, upper_byte_select_low_out, lower_byte_select_low_out;
  logic [17:0] req_addr_in = '0;
  logic [1:0]  req_be_in = '0;
  logic [15:0] req_wdata_in = '0, rdata_out, dq_in, dq_out, mdq, lf = 16'hBB94;
  logic [7:0]  prot_byte_in = '0, pq = '0;
  logic [16:0] mem_addr_out;
  bit   [15:0] rm [131072];
  nvhc_note_t  q [$];
  int          n_mismatch = 0, checks_done = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  assign dq_in = dq_oe_out ? dq_out : mdq;
  nvhc_host i_dut (.*);
  nvhc_mem_model i_mem (.cs_n_in(chip_select_low_out), .we_n_in(write_strobe_low_out),
    .oe_n_in(output_enable_low_out), .ub_n_in(upper_byte_select_low_out),
    .lb_n_in(lower_byte_select_low_out), .addr_in(mem_addr_out), .dq_in(dq_in), .dq_out(mdq));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (n == 200) chk("wait", 16'h0001, 16'h0000);
  endtask
  task automatic acc(logic w, logic [17:0] a, logic [1:0] be, logic [15:0] d, logic bm);
    logic [16:0] wa;
    logic [15:0] m;
    wa = bm ? a[17:1] : a[16:0];
    m = bm ? (a[0] ? 16'hFF00 : 16'h00FF) : {{8{be[1]}}, {8{be[0]}}};
    wt(ready_out);
    {req_valid_in, req_write_in, req_addr_in, req_be_in, req_wdata_in, byte_mode_in} = {1'b1, w, a, be, d, bm};
    if (!w) q.push_back('{bm ? {8'h00, a[0] ? rm[wa][15:8] : rm[wa][7:0]} : rm[wa], bm ? 16'h00FF : m});
    else q.push_back('{16'h0000, 16'h0000});
    if (w && !pq[wa[16:14]]) rm[wa] = (rm[wa] & ~m) | ((bm ? {2{d[7:0]}} : d) & m);
    @(posedge ref_clk_in);
    #1;
    req_valid_in = 0;
    wt(done_out);
  endtask
  task automatic prot(logic [7:0] b);
    repeat (4) @(posedge ref_clk_in);
    #1;
    prot_start_in = 1;
    prot_byte_in = b;
    @(posedge ref_clk_in);
    #1;
    prot_start_in = 0;
    wt(prot_done_out);
    pq = b;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    #2;
    if (done_out === 1'b1 && q.size() == 0) chk("note", 16'h0000, 16'h0001);
    else if (done_out === 1'b1) begin
      chk("rdata", q[0].e & q[0].m, rdata_out & q[0].m);
      q.delete(0);
    end
  end
  initial begin
    #3000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [15:0] r;
    logic [16:0] a;
    // Lowered after time zero so the asynchronous reset edge is seen
    #1 arst_n_in = 0;
    repeat (20) @(posedge ref_clk_in);
    #1 arst_n_in = 1;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      acc(1, {1'b0, r[0], r}, r[5:4], rnd(), 0);
      acc(0, {1'b0, r[0], r}, 2'b11, 16'h0000, 0);
    end
    a = {rnd(), 1'b0};
    for (int c = 0; c < 4; c++) acc(1, {1'b0, a[16:2], c[1:0]}, 2'b11, rnd(), 0);
    for (int c = 3; c >= 0; c--) acc(0, {1'b0, a[16:2], c[1:0]}, 2'b11, 16'h0000, 0);
    for (int l = 0; l < 2; l++) acc(1, {a, l[0]}, 2'b00, rnd(), 1);
    for (int l = 0; l < 2; l++) acc(0, {a, l[0]}, 2'b00, 16'h0000, 1);
    acc(0, {1'b0, a}, 2'b11, 16'h0000, 0);
    prot(8'h18);
    acc(1, 18'h0_C000, 2'b11, 16'h1234, 0);
    acc(1, 18'h0_0010, 2'b11, 16'h5678, 0);
    acc(0, 18'h0_C000, 2'b11, 16'h0000, 0);
    @(posedge ref_clk_in);
    #1 arst_n_in = 0;
    repeat (3) @(posedge ref_clk_in);
    #1 arst_n_in = 1;
    acc(0, 18'h0_0010, 2'b11, 16'h0000, 0);
    repeat (4) @(posedge ref_clk_in);
    chk("notes", 16'h0000, 16'(q.size()));
    give_verdict();
  end
endmodule
